// ===== rtl/reset_seq_pkg.sv
// Shared constants for the reset release and clock select block.
`default_nettype none
package reset_seq_pkg;
	// Core clock rate in MHz (5 ns period).
	localparam int CLK_MHZ = 200;
	// Power-up timer nominal time with the regulator off, in ms.
	localparam int POWER_UP_TIMER_MS = 64;
	// Power-up timer length in core cycles.
	localparam int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_MS * CLK_MHZ * 1000;
	// Power-on delay, RC start-up and regulator-on timer defaults in cycles.
	localparam int POR_CYCLES = 400;
	localparam int POWER_UP_TIMER_REG_ON_CYCLES = 16;
	localparam int FRC_CYCLES = 200;
	localparam int LOW_POWER_RC_OSC_CYCLES = 600;
	// Start-up timer counts this many oscillator periods.
	localparam int OST_PERIODS = 1024;
	localparam int OST_WIDTH = 10;
	// Oscillator select codes.
	localparam logic [2:0] OSC_FAST_RC = 3'h0;
	localparam logic [2:0] OSC_FAST_RC_PLL = 3'h1;
	localparam logic [2:0] OSC_PRIMARY = 3'h2;
	localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;
	localparam logic [2:0] OSC_SECONDARY = 3'h4;
	localparam logic [2:0] OSC_LOW_POWER_RC = 3'h5;
	localparam logic [2:0] OSC_FAST_RC_DIV = 3'h7;
	// Register addresses.
	localparam logic [2:0] ADDR_CAUSE = 3'h0;
	localparam logic [2:0] ADDR_OSC = 3'h1;
	localparam logic [2:0] ADDR_RTC_CAL = 3'h2;
	localparam logic [2:0] ADDR_NVM = 3'h3;
	localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
	localparam logic [2:0] ADDR_STATE = 3'h6;
	// Reset-cause bit positions and power-on value.
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_BOR = 1;
	localparam int CAUSE_WDT = 4;
	localparam int CAUSE_SW = 6;
	localparam int CAUSE_PIN = 7;
	localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;
	// Oscillator control fields: current select and new select.
	localparam int OSC_CUR_LSB = 12;
	localparam int OSC_NEW_LSB = 8;
	// Interrupt event bit positions.
	localparam int EV_RESET_DONE = 0;
	localparam int EV_CLOCK_DONE = 1;
	localparam int EV_CLOCK_FAIL = 2;
	// Kind of the last reset, which picks the release delay.
	typedef enum logic [1:0] {KIND_OTHER, KIND_BROWN_OUT, KIND_POWER_ON} reset_kind_type;
endpackage
`default_nettype wire

// ===== rtl/reset_release_clock_select.sv
// Reset release sequencer with reset-time clock selection and code-run gate.
// Summary of operation
// - Switching on: power resets use config, others current
// - Switching off: always use oscillator configuration
// - Hold reset until power-on and power-up delays
// - Power-on both delays, brown-out timer only
// - Power-up timer nominally 64 ms, regulator off
// - Crystal start-up counts 1024 oscillator periods
// - Clock waits run alongside reset delays
// - Clock delay chosen by source type
// - Two-speed start uses fast RC timing
// - No code runs before clock released
// - Fail monitor starts at reset release
// - No clock: switch fast RC, raise trap
// - Other registers share one reset value
// - Reset-cause value depends on reset type
// - Oscillator control reset depends type, config
// - Calibration, memory control reset only power-on
// - Any reset source asserts system reset
// - Power-on leaves only brown-out, power-on flags
//
// Local design decisions: the address map and strobed register access.
`default_nettype none
module reset_release_clock_select #(
	parameter int POR_CYCLES = reset_seq_pkg::POR_CYCLES,
	parameter int POWER_UP_TIMER_CYCLES = reset_seq_pkg::POWER_UP_TIMER_CYCLES,
	parameter int POWER_UP_TIMER_REG_ON_CYCLES = reset_seq_pkg::POWER_UP_TIMER_REG_ON_CYCLES,
	parameter int FRC_CYCLES = reset_seq_pkg::FRC_CYCLES,
	parameter int LOW_POWER_RC_OSC_CYCLES = reset_seq_pkg::LOW_POWER_RC_OSC_CYCLES
) (
	// Clock and power-on reset.
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Reset sources, high while active.
	input  wire logic        brown_out_reset,
	input  wire logic        pin_reset,
	input  wire logic        watchdog_timeout_reset,
	input  wire logic        software_reset,
	// Configuration bits.
	input  wire logic        clk_switch_en,
	input  wire logic        two_speed_en,
	input  wire logic        fail_monitor_en,
	input  wire logic        regulator_enable_pin,
	input  wire logic        primary_is_crystal,
	input  wire logic [2:0]  new_osc_select_cfg,
	// Oscillator status.
	input  wire logic        osc_period_tick,
	input  wire logic        pll_locked,
	input  wire logic        osc_valid,
	// Register port.
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Results.
	output logic             system_reset_signal,
	output logic             clock_released,
	output logic             cpu_run,
	output logic             monitor_active,
	output logic             fail_trap,
	output logic      [2:0]  current_osc_select,
	output logic             irq
);
	// Refuse delays the counters cannot hold.
	if (POR_CYCLES < 1 || POWER_UP_TIMER_CYCLES < 1 || POWER_UP_TIMER_REG_ON_CYCLES < 1 || FRC_CYCLES < 1 ||
		LOW_POWER_RC_OSC_CYCLES < 1) begin : g_bad_param
		$error("All delay counts must be at least one cycle.");
	end

	typedef enum logic [1:0] {SEQ_HOLD, SEQ_POR, SEQ_POWER_UP_TIMER, SEQ_RUN} seq_state_type;
	typedef enum logic [2:0] {CK_IDLE, CK_RC, CK_OST, CK_LOCK, CK_READY} ck_state_type;

	// Reset sequencer state and delay counter.
	seq_state_type               seq_reg, seq_next;
	reset_seq_pkg::reset_kind_type kind_reg, kind_next;
	logic [31:0]                 dly_reg, dly_next;
	// Clock release state, RC counter and start-up timer.
	ck_state_type                ck_reg, ck_next;
	logic [31:0]                 rc_reg, rc_next;
	logic [reset_seq_pkg::OST_WIDTH-1:0] ost_reg, ost_next;
	logic                        need_ost_reg, need_ost_next;
	logic                        need_lock_reg, need_lock_next;
	// Registers visible to software.
	logic [15:0]                 cause_reg, cause_next;
	logic [15:0]                 osc_control_reg, osc_control_next;
	logic [15:0]                 rtc_calibration_reg, rtc_calibration_next;
	logic [15:0]                 nvm_control_reg, nvm_control_next;
	logic [2:0]                  irq_status_reg, irq_status_next;
	logic [2:0]                  irq_mask_reg, irq_mask_next;
	logic                        monitor_reg, monitor_next;
	logic                        trap_reg, trap_next;
	logic [15:0]                 rdata_next;
	// Helper terms.
	logic                        src_any;
	logic                        leave_hold;
	logic [31:0]                 power_up_timer_len;
	logic [2:0]                  sel_osc;
	logic [2:0]                  eff_osc;
	logic                        release_now;
	logic                        clock_fail;

	assign src_any = brown_out_reset | pin_reset | watchdog_timeout_reset | software_reset;
	assign system_reset_signal = src_any | (seq_reg != SEQ_RUN);
	assign leave_hold = (seq_reg == SEQ_HOLD) && !src_any;
	assign power_up_timer_len = regulator_enable_pin ? 32'(POWER_UP_TIMER_REG_ON_CYCLES) : 32'(POWER_UP_TIMER_CYCLES);
	assign release_now = system_reset_signal && !src_any && (seq_next == SEQ_RUN);
	assign clock_released = (ck_reg == CK_READY);
	// code runs only once clock and reset allow
	assign cpu_run = clock_released && !system_reset_signal;
	assign monitor_active = monitor_reg;
	assign fail_trap = trap_reg;
	assign current_osc_select = osc_control_reg[reset_seq_pkg::OSC_CUR_LSB +: 3];
	assign irq = |(irq_status_reg & irq_mask_reg);
	assign clock_fail = fail_monitor_en && !osc_valid && !trap_reg &&
		(release_now || (monitor_reg && current_osc_select != reset_seq_pkg::OSC_FAST_RC));

	// Clock source chosen as the reset hold ends.
	always_comb begin
		// with switching on, power resets reload config, others keep current
		if (clk_switch_en && kind_reg == reset_seq_pkg::KIND_OTHER) begin
			sel_osc = current_osc_select;
		end else begin
			// configuration always wins when switching is off
			sel_osc = new_osc_select_cfg;
		end
		// two-speed start runs from fast RC first
		if (two_speed_en && (sel_osc == reset_seq_pkg::OSC_PRIMARY ||
			sel_osc == reset_seq_pkg::OSC_PRIMARY_PLL ||
			sel_osc == reset_seq_pkg::OSC_SECONDARY)) begin
			eff_osc = reset_seq_pkg::OSC_FAST_RC;
		end else begin
			eff_osc = sel_osc;
		end
	end

	// Reset sequencer next state.
	always_comb begin
		seq_next = seq_reg;
		kind_next = kind_reg;
		dly_next = dly_reg;
		if (src_any) begin
			// A brown-out outranks the softer sources for the delay choice.
			seq_next = SEQ_HOLD;
			dly_next = 32'h0;
			if (brown_out_reset && kind_reg != reset_seq_pkg::KIND_POWER_ON) begin
				kind_next = reset_seq_pkg::KIND_BROWN_OUT;
			end
		end else begin
			unique case (seq_reg)
				SEQ_HOLD: begin
					// pick the delay from the reset kind
					if (kind_reg == reset_seq_pkg::KIND_POWER_ON) begin
						seq_next = SEQ_POR;
					end else if (kind_reg == reset_seq_pkg::KIND_BROWN_OUT) begin
						seq_next = SEQ_POWER_UP_TIMER;
					end else begin
						seq_next = SEQ_RUN;
					end
				end
				SEQ_POR: begin
					if (dly_reg == 32'(POR_CYCLES - 1)) begin
						seq_next = SEQ_POWER_UP_TIMER;
						dly_next = 32'h0;
					end else begin
						dly_next = dly_reg + 32'h1;
					end
				end
				SEQ_POWER_UP_TIMER: begin
					// release only after the power-up timer
					if (dly_reg == power_up_timer_len - 32'h1) begin
						seq_next = SEQ_RUN;
					end else begin
						dly_next = dly_reg + 32'h1;
					end
				end
				SEQ_RUN: begin
					kind_next = reset_seq_pkg::KIND_OTHER;
				end
			endcase
		end
	end

	// Reset sequencer registers.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seq_reg <= SEQ_HOLD;
			kind_reg <= reset_seq_pkg::KIND_POWER_ON;
			dly_reg <= 32'h0;
		end else begin
			seq_reg <= seq_next;
			kind_reg <= kind_next;
			dly_reg <= dly_next;
		end
	end

	// Clock release next state.
	always_comb begin
		ck_next = ck_reg;
		rc_next = rc_reg;
		ost_next = ost_reg;
		need_ost_next = need_ost_reg;
		need_lock_next = need_lock_reg;
		if (src_any) begin
			ck_next = CK_IDLE;
		end else begin
			unique case (ck_reg)
				CK_IDLE: begin
					// start with the reset delay, not after it
					if (leave_hold) begin
						rc_next = 32'h0;
						ost_next = '0;
						need_ost_next = (eff_osc == reset_seq_pkg::OSC_SECONDARY) ||
							(primary_is_crystal && (eff_osc == reset_seq_pkg::OSC_PRIMARY ||
							eff_osc == reset_seq_pkg::OSC_PRIMARY_PLL));
						need_lock_next = (eff_osc == reset_seq_pkg::OSC_FAST_RC_PLL) ||
							(eff_osc == reset_seq_pkg::OSC_PRIMARY_PLL);
						if (eff_osc == reset_seq_pkg::OSC_PRIMARY_PLL && primary_is_crystal &&
							kind_reg == reset_seq_pkg::KIND_BROWN_OUT) begin
							// After brown-out a crystal PLL waits on fast RC, not the crystal.
							need_ost_next = 1'b0;
							ck_next = CK_RC;
						end else if (eff_osc == reset_seq_pkg::OSC_FAST_RC ||
							eff_osc == reset_seq_pkg::OSC_FAST_RC_PLL ||
							eff_osc == reset_seq_pkg::OSC_FAST_RC_DIV ||
							eff_osc == reset_seq_pkg::OSC_LOW_POWER_RC) begin
							ck_next = CK_RC;
						end else if (need_ost_next) begin
							ck_next = CK_OST;
						end else if (need_lock_next) begin
							ck_next = CK_LOCK;
						end else begin
							ck_next = CK_READY;
						end
					end
				end
				CK_RC: begin
					// RC start-up time, low-power RC being the slower one.
					if (rc_reg == ((eff_osc == reset_seq_pkg::OSC_LOW_POWER_RC) ?
						32'(LOW_POWER_RC_OSC_CYCLES - 1) : 32'(FRC_CYCLES - 1))) begin
						ck_next = need_lock_reg ? CK_LOCK : CK_READY;
					end else begin
						rc_next = rc_reg + 32'h1;
					end
				end
				CK_OST: begin
					if (osc_period_tick) begin
						ost_next = ost_reg + 1'b1;
						if (ost_reg == reset_seq_pkg::OST_WIDTH'(reset_seq_pkg::OST_PERIODS - 1)) begin
							ck_next = need_lock_reg ? CK_LOCK : CK_READY;
						end
					end
				end
				CK_LOCK: begin
					if (pll_locked) begin
						ck_next = CK_READY;
					end
				end
				CK_READY: begin
					ck_next = CK_READY;
				end
				default: begin
					ck_next = CK_IDLE;
				end
			endcase
		end
	end

	// Clock release registers.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ck_reg <= CK_IDLE;
			rc_reg <= 32'h0;
			ost_reg <= '0;
			need_ost_reg <= 1'b0;
			need_lock_reg <= 1'b0;
		end else begin
			ck_reg <= ck_next;
			rc_reg <= rc_next;
			ost_reg <= ost_next;
			need_ost_reg <= need_ost_next;
			need_lock_reg <= need_lock_next;
		end
	end

	// Software registers, monitor and events.
	always_comb begin
		cause_next = cause_reg;
		osc_control_next = osc_control_reg;
		rtc_calibration_next = rtc_calibration_reg;
		nvm_control_next = nvm_control_reg;
		irq_status_next = irq_status_reg;
		irq_mask_next = irq_mask_reg;
		monitor_next = monitor_reg;
		trap_next = 1'b0;
		rdata_next = 16'h0000;
		if (reg_wr) begin
			unique case (reg_addr)
				reset_seq_pkg::ADDR_CAUSE: cause_next = reg_wdata;
				reset_seq_pkg::ADDR_OSC: osc_control_next[reset_seq_pkg::OSC_NEW_LSB +: 3] =
					reg_wdata[reset_seq_pkg::OSC_NEW_LSB +: 3];
				reset_seq_pkg::ADDR_RTC_CAL: rtc_calibration_next = reg_wdata;
				reset_seq_pkg::ADDR_NVM: nvm_control_next = reg_wdata;
				reset_seq_pkg::ADDR_IRQ_STATUS: irq_status_next = irq_status_reg & ~reg_wdata[2:0];
				reset_seq_pkg::ADDR_IRQ_MASK: irq_mask_next = reg_wdata[2:0];
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				reset_seq_pkg::ADDR_CAUSE: rdata_next = cause_reg;
				reset_seq_pkg::ADDR_OSC: rdata_next = osc_control_reg;
				reset_seq_pkg::ADDR_RTC_CAL: rdata_next = rtc_calibration_reg;
				reset_seq_pkg::ADDR_NVM: rdata_next = nvm_control_reg;
				reset_seq_pkg::ADDR_IRQ_STATUS: rdata_next = {13'h0000, irq_status_reg};
				reset_seq_pkg::ADDR_IRQ_MASK: rdata_next = {13'h0000, irq_mask_reg};
				reset_seq_pkg::ADDR_STATE: rdata_next = {11'h000, trap_reg, monitor_reg,
					cpu_run, clock_released, system_reset_signal};
				default: rdata_next = 16'h0000;
			endcase
		end
		// hardware sets the flag of each reset, over software
		if (brown_out_reset) cause_next[reset_seq_pkg::CAUSE_BOR] = 1'b1;
		if (pin_reset) cause_next[reset_seq_pkg::CAUSE_PIN] = 1'b1;
		if (watchdog_timeout_reset) cause_next[reset_seq_pkg::CAUSE_WDT] = 1'b1;
		if (software_reset) cause_next[reset_seq_pkg::CAUSE_SW] = 1'b1;
		// current select loaded as the reset hold ends
		if (leave_hold) begin
			osc_control_next[reset_seq_pkg::OSC_CUR_LSB +: 3] = eff_osc;
			if (kind_reg != reset_seq_pkg::KIND_OTHER) begin
				osc_control_next[reset_seq_pkg::OSC_NEW_LSB +: 3] = new_osc_select_cfg;
			end
		end
		// monitor starts as the system reset drops
		if (release_now && fail_monitor_en) begin
			monitor_next = 1'b1;
		end
		// no valid clock: fall back to fast RC and trap
		if (clock_fail) begin
			osc_control_next[reset_seq_pkg::OSC_CUR_LSB +: 3] = reset_seq_pkg::OSC_FAST_RC;
			trap_next = 1'b1;
		end
		// Events set after a clear in the same cycle, so none is lost.
		if (release_now) irq_status_next[reset_seq_pkg::EV_RESET_DONE] = 1'b1;
		if (ck_next == CK_READY && ck_reg != CK_READY) begin
			irq_status_next[reset_seq_pkg::EV_CLOCK_DONE] = 1'b1;
		end
		if (clock_fail) irq_status_next[reset_seq_pkg::EV_CLOCK_FAIL] = 1'b1;
		// ordinary registers take one value on any reset
		if (src_any) begin
			irq_status_next = 3'h0;
			irq_mask_next = 3'h0;
			monitor_next = 1'b0;
			osc_control_next[reset_seq_pkg::OSC_NEW_LSB +: 3] = 3'h0;
		end
	end

	// Software registers; calibration and memory control clear on power-on only.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// power-on leaves only two flags set
			cause_reg <= reset_seq_pkg::CAUSE_POR_VALUE;
			osc_control_reg <= 16'h0000;
			rtc_calibration_reg <= 16'h0000;
			nvm_control_reg <= 16'h0000;
			irq_status_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
			monitor_reg <= 1'b0;
			trap_reg <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			cause_reg <= cause_next;
			osc_control_reg <= osc_control_next;
			rtc_calibration_reg <= rtc_calibration_next;
			nvm_control_reg <= nvm_control_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			monitor_reg <= monitor_next;
			trap_reg <= trap_next;
			reg_rdata <= rdata_next;
		end
	end

	// Checks on the sequencing.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_power_up_timer_done;
		seq_reg == SEQ_POWER_UP_TIMER && !src_any && dly_reg == power_up_timer_len - 32'h1;
	endsequence

	chk_source_holds_reset: assert property (src_any |-> system_reset_signal)
		else $error("Reset source active but system reset low.");
	chk_release_after_power_up_timer: assert property (
		(seq_reg == SEQ_POWER_UP_TIMER && seq_next == SEQ_RUN) |-> (dly_reg == power_up_timer_len - 32'h1))
		else $error("System reset released before power-up timer end.");
	chk_power_up_timer_to_run: assert property (s_power_up_timer_done |=> !system_reset_signal || src_any)
		else $error("Power-up timer expired but reset still held.");
	chk_brown_out_skip: assert property (
		(leave_hold && kind_reg == reset_seq_pkg::KIND_BROWN_OUT) |=> seq_reg == SEQ_POWER_UP_TIMER)
		else $error("Brown-out release did not go to power-up timer.");
	chk_other_no_delay: assert property (
		(leave_hold && kind_reg == reset_seq_pkg::KIND_OTHER) |=> !system_reset_signal || src_any)
		else $error("Soft reset release was delayed.");
	chk_ost_full_count: assert property (
		(ck_reg == CK_OST && ck_next != CK_OST && !src_any) |->
		(osc_period_tick && ost_reg == reset_seq_pkg::OST_WIDTH'(reset_seq_pkg::OST_PERIODS - 1)))
		else $error("Start-up timer left early.");
	chk_no_early_run: assert property (cpu_run |-> (ck_reg == CK_READY && seq_reg == SEQ_RUN))
		else $error("Core runs without released clock.");
	chk_monitor_start: assert property ((release_now && fail_monitor_en) |=> monitor_active)
		else $error("Fail monitor did not start at reset release.");
	chk_fail_fallback: assert property (
		fail_trap |-> (current_osc_select == reset_seq_pkg::OSC_FAST_RC && irq_status_reg[2]))
		else $error("Clock failure without fast RC fallback.");
	chk_cal_kept: assert property (
		(src_any && !reg_wr) |=> $stable(rtc_calibration_reg) && $stable(nvm_control_reg))
		else $error("Calibration or memory control changed on soft reset.");
	chk_cause_flag: assert property (watchdog_timeout_reset |=> cause_reg[4])
		else $error("Watchdog flag not set by its reset.");
endmodule
`default_nettype wire

// ===== dv/osc_source_model.sv
// Oscillator block model: period ticks, PLL lock and presence.
`default_nettype none
module osc_source_model #(
	parameter int LOCK_CYCLES = 40
) (
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic rst,
	// Dead oscillator request.
	input  wire logic osc_fail,
	// Status toward the block.
	output logic      osc_period_tick,
	output logic      pll_locked,
	output logic      osc_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// Toggles each cycle, so the crystal ticks every second cycle.
	logic phase_reg;
	// Cycles since power-on, for the PLL lock.
	int   lock_cnt;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= 1'b0;
			lock_cnt <= 0;
		end else begin
			phase_reg <= ~phase_reg;
			lock_cnt <= (lock_cnt < LOCK_CYCLES) ? lock_cnt + 1 : lock_cnt;
		end
	end
	// A dead oscillator gives no ticks and reports itself absent.
	assign osc_period_tick = phase_reg & ~osc_fail;
	assign osc_valid = ~osc_fail;
	assign pll_locked = (lock_cnt >= LOCK_CYCLES);
endmodule
`default_nettype wire

// ===== dv/reset_release_clock_select_bench.sv
// Self-checking bench for the reset release and clock select block.
`default_nettype none
module reset_release_clock_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Shortened delays, expectations derive from these.
	localparam int POR_N = 5;
	localparam int POWER_UP_TIMER_N = 50;
	logic core_clk = 1'b0, rst = 1'b1, osc_fail = 1'b0;
	logic [3:0] src = 4'h0;
	logic clk_switch_en = 1'b1, two_speed_en = 1'b0, fail_monitor_en = 1'b1;
	logic regulator_enable_pin = 1'b0, primary_is_crystal = 1'b1;
	logic [2:0] new_osc_select_cfg = 3'h2, reg_addr = 3'h0, current_osc_select;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rdata, rtc_val;
	logic reg_wr = 1'b0, reg_rd = 1'b0, system_reset_signal, clock_released, cpu_run;
	logic osc_period_tick, pll_locked, osc_valid, monitor_active, fail_trap, irq;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	int k;
	// Half-period toggle for 200 MHz.
	always #2.5 core_clk = ~core_clk;
	// Oscillator partner.
	osc_source_model osc_u (.core_clk, .rst, .osc_fail, .osc_period_tick, .pll_locked, .osc_valid);
	// Block under test with shortened counts.
	reset_release_clock_select #(.POR_CYCLES(POR_N), .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_N), .FRC_CYCLES(3),
		.LOW_POWER_RC_OSC_CYCLES(4)) dut_u (.core_clk, .rst, .brown_out_reset(src[0]), .pin_reset(src[1]),
		.watchdog_timeout_reset(src[2]), .software_reset(src[3]), .clk_switch_en,
		.two_speed_en, .fail_monitor_en, .regulator_enable_pin, .primary_is_crystal,
		.new_osc_select_cfg, .osc_period_tick, .pll_locked, .osc_valid, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .system_reset_signal, .clock_released,
		.cpu_run, .monitor_active, .fail_trap, .current_osc_select, .irq);
	// Compares one value and counts the comparison.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read; data is taken in the following cycle.
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Counts cycles until the system reset drops, bounded.
	task automatic wait_release(output int cyc);
		cyc = 0;
		while (system_reset_signal !== 1'b0 && cyc < 4000) begin
			@(posedge core_clk);
			#1 cyc++;
		end
	endtask
	// Pulses one reset source for one cycle.
	task automatic pulse(input int which);
		@(posedge core_clk);
		src <= 4'h1 << which;
		#1 check("system_reset_signal on source", system_reset_signal, 1'b1);
		@(posedge core_clk);
		src <= 4'h0;
	endtask
	// Prints the verdict and ends the run.
	task automatic summarize();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// The code gate must equal clock released and not in reset.
	always @(negedge core_clk) begin
		if (!rst) check("cpu_run", cpu_run, clock_released & ~system_reset_signal);
	end
	// Cuts a hang short.
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
	// Main sequence.
	initial begin
		n = $urandom(32'h249517dc);
		rtc_val = 16'($urandom);
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		wait_release(n);
		check("por delay", 16'(n >= POR_N + POWER_UP_TIMER_N && n <= POR_N + POWER_UP_TIMER_N + 3), 1);
		check("clock gate early", clock_released, 1'b0);
		while (clock_released !== 1'b1 && n < 4000) begin
			@(posedge core_clk);
			#1 n++;
		end
		check("ost overlaps reset", 16'(n >= 2040 && n <= 2060), 1);
		rd(reset_seq_pkg::ADDR_CAUSE, rdata);
		check("cause after por", rdata, 16'h0003);
		rd(reset_seq_pkg::ADDR_OSC, rdata);
		check("osc after por", rdata, 16'h2200);
		wr(reset_seq_pkg::ADDR_RTC_CAL, rtc_val);
		new_osc_select_cfg <= 3'h4;
		// Pin, watchdog and software resets in turn.
		for (k = 1; k < 4; k++) begin
			wr(reset_seq_pkg::ADDR_CAUSE, 16'h0000);
			pulse(k);
			wait_release(n);
			check("no release delay", 16'(n <= 2), 1);
			rd(reset_seq_pkg::ADDR_CAUSE, rdata);
			check("cause bit", rdata, 16'h1 << (k == 1 ? 7 : (k == 2 ? 4 : 6)));
			check("osc kept", 16'(current_osc_select), 16'h2);
			rd(reset_seq_pkg::ADDR_RTC_CAL, rdata);
			check("rtc kept", rdata, rtc_val);
		end
		two_speed_en <= 1'b1;
		pulse(0);
		wait_release(n);
		check("brown-out delay", 16'(n >= POWER_UP_TIMER_N && n <= POWER_UP_TIMER_N + 3), 1);
		check("two-speed clock", clock_released, 1'b1);
		rd(reset_seq_pkg::ADDR_OSC, rdata);
		check("osc from config", rdata, 16'h0400);
		check("two-speed on fast rc", 16'(current_osc_select), 16'h0);
		two_speed_en <= 1'b0;
		clk_switch_en <= 1'b0;
		new_osc_select_cfg <= 3'h2;
		osc_fail <= 1'b1;
		pulse(1);
		wait_release(n);
		check("osc switching off", 16'(n <= 2), 1);
		n = 0;
		while (fail_trap !== 1'b1 && n < 4) begin
			@(posedge core_clk);
			#1 n++;
		end
		check("trap at release", fail_trap, 1'b1);
		check("fall to fast rc", 16'(current_osc_select), 16'h0);
		check("monitor on", monitor_active, 1'b1);
		#2 check("irq masked off", irq, 1'b0);
		// The mask is cleared by every reset, so it is set after the release.
		wr(reset_seq_pkg::ADDR_IRQ_MASK, 16'h0004);
		#1 check("irq raised", irq, 1'b1);
		osc_fail <= 1'b0;
		wr(reset_seq_pkg::ADDR_IRQ_STATUS, 16'h0004);
		#1 check("irq cleared", irq, 1'b0);
		rd(3'h7, rdata);
		check("unmapped read", rdata, 16'h0000);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		wait_release(n);
		rd(reset_seq_pkg::ADDR_RTC_CAL, rdata);
		check("rtc cleared", rdata, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
